// ---- spd_pkg.sv ----
// package of constants for the supply protection diagnostic registers
package spd_pkg;
  // ==========================================================
  // register addresses
  localparam int unsigned ADDR_W           = 8;
  localparam logic [7:0]  ADDR_DIAG_FLAGS  = 8'h00;
  localparam logic [7:0]  ADDR_DIAG_SPARE  = 8'h01;
  localparam logic [7:0]  ADDR_LEVEL_SEL   = 8'h02;
  localparam logic [7:0]  ADDR_PROT_CFG    = 8'h05;
  localparam logic [7:0]  NUM_REGS         = 8'h06;
  // ==========================================================
  // protection configuration fields
  localparam int unsigned CFG_OVL_REC_BIT  = 3;
  localparam int unsigned CFG_TEMP_REC_BIT = 6;
  localparam int unsigned CFG_COMP_BIT     = 7;
  localparam logic [7:0]  CFG_WR_MASK      = 8'hC8;
  // ==========================================================
  // diagnostic flag fields
  localparam int unsigned FLG_OL_A_BIT     = 0;
  localparam int unsigned FLG_OL_B_BIT     = 1;
  localparam int unsigned FLG_OT_BIT       = 6;
  localparam int unsigned FLG_LOWIN_BIT    = 7;
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [3:0]  LVL_OFF          = 4'h0;
endpackage

// ---- spd_regmem.sv ----
// small byte memory for plain read-write data registers
`timescale 1ns/1ps
`default_nettype none
module spd_regmem #(
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wr_addr,
  input  wire logic [7:0]       wr_data,
  input  wire logic [7:0]       rd_addr,
  output logic      [7:0]       rd_data
);
  import spd_pkg::*;
  logic [DEPTH-1:0][7:0] mem_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_q   <= '0;
      rd_data <= RST_BYTE;
    end else begin
      if (wr_en && (wr_addr < DEPTH)) begin
        mem_q[wr_addr[$clog2(DEPTH)-1:0]] <= wr_data;
      end
      if (rd_addr < DEPTH) begin
        rd_data <= mem_q[rd_addr[$clog2(DEPTH)-1:0]];
      end else begin
        rd_data <= RST_BYTE;
      end
    end
  end
endmodule
`default_nettype wire

// ---- spd_top.sv ----
// protection configuration and diagnostic status register bank
`timescale 1ns/1ps
`default_nettype none
// Contract
// - protection config at address 0x5, read-write
// - overload latch mode clears levels, disables output
// - auto mode re-enables output, levels kept
// - thermal latch mode bit6 clears levels, disables
// - thermal auto mode re-enables with prior levels
// - bit7 selects boost compensation type
// - status registers read-only, writes ignored
// - status 0x0 bits0,1 overload flags per channel
// - status bit6 shared overtemperature flag
// - status bit7 low input voltage flag
// - status 0x1 readable, all reserved
// - all bits clear at power-on
// - level selects at 0x2, A low, B high
// - data register reads return last written
module spd_top (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      reg_wr,
  input  wire logic [spd_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      overload_a_raw,
  input  wire logic                      overload_b_raw,
  input  wire logic                      overtemp_raw,
  input  wire logic                      low_input_raw,
  output logic      [3:0]                output_level_select_a,
  output logic      [3:0]                output_level_select_b,
  output logic                           supply_output_en_a,
  output logic                           supply_output_en_b,
  output logic                           boost_comp_ceramic
);
  import spd_pkg::*;

  // ==========================================================
  // helper functions
  // compare an address with one register
  function automatic logic addr_is(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    addr_is = (addr == target);
  endfunction

  // latched trip for one channel
  function automatic logic latch_trip(
    input logic       ovl,
    input logic       hot,
    input logic [7:0] cfg
  );
    logic by_ovl;
    logic by_hot;
    by_ovl     = ovl && cfg[CFG_OVL_REC_BIT];
    by_hot     = hot && cfg[CFG_TEMP_REC_BIT];
    latch_trip = by_ovl || by_hot;
  endfunction

  // channel may drive its output
  function automatic logic chan_ok(
    input logic ovl,
    input logic hot,
    input logic trip
  );
    chan_ok = !ovl && !hot && !trip;
  endfunction

  // level zero means standby
  function automatic logic level_on(
    input logic [3:0] lvl
  );
    level_on = (lvl != LVL_OFF);
  endfunction

  // reserved config bits dropped
  function automatic logic [7:0] cfg_masked(
    input logic [7:0] wdata
  );
    cfg_masked = wdata & CFG_WR_MASK;
  endfunction

  // assemble the first status byte
  function automatic logic [7:0] pack_flags(
    input logic ovl_a,
    input logic ovl_b,
    input logic hot,
    input logic low_in
  );
    logic [7:0] f;
    f                = RST_BYTE;
    f[FLG_OL_A_BIT]  = ovl_a;
    f[FLG_OL_B_BIT]  = ovl_b;
    f[FLG_OT_BIT]    = hot;
    f[FLG_LOWIN_BIT] = low_in;
    pack_flags       = f;
  endfunction

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] ol_s1;
    logic [1:0] ol_s2;
    logic       ot_s1;
    logic       ot_s2;
    logic       li_s1;
    logic       li_s2;
    logic [7:0] cfg;
    logic [7:0] lvl;
    logic [7:0] flags;
    logic [7:0] addr;
    logic       en_a;
    logic       en_b;
  } spd_state_t;

  spd_state_t st_q;
  spd_state_t st_d;
  logic [7:0] mem_rdata;
  logic       mem_wr;
  logic       wr_cfg;
  logic       wr_lvl;
  logic       wr_status;

  // ==========================================================
  // address decode
  assign wr_cfg    = reg_wr && addr_is(reg_addr, ADDR_PROT_CFG);
  assign wr_lvl    = reg_wr && addr_is(reg_addr, ADDR_LEVEL_SEL);
  assign wr_status = reg_wr && (reg_addr <= ADDR_DIAG_SPARE);

  // ==========================================================
  // other data registers kept in the byte memory
  assign mem_wr = reg_wr && !wr_cfg && !wr_lvl && !wr_status;

  spd_regmem #(
    .DEPTH (8)
  ) u_mem (
    .clk     (clk),
    .resetn  (resetn),
    .wr_en   (mem_wr),
    .wr_addr (reg_addr),
    .wr_data (reg_wdata),
    .rd_addr (reg_addr),
    .rd_data (mem_rdata)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic ol_a;
    logic ol_b;
    logic ot;
    logic trip_a;
    logic trip_b;
    ol_a   = 1'b0;
    ol_b   = 1'b0;
    ot     = 1'b0;
    trip_a = 1'b0;
    trip_b = 1'b0;
    st_d   = st_q;
    // pin synchronisers
    st_d.ol_s1 = {overload_b_raw, overload_a_raw};
    st_d.ol_s2 = st_q.ol_s1;
    st_d.ot_s1 = overtemp_raw;
    st_d.ot_s2 = st_q.ot_s1;
    st_d.li_s1 = low_input_raw;
    st_d.li_s2 = st_q.li_s1;
    ol_a = st_q.ol_s2[0];
    ol_b = st_q.ol_s2[1];
    ot   = st_q.ot_s2;
    // status flags follow live conditions
    st_d.flags = pack_flags(ol_a, ol_b, ot, st_q.li_s2);
    // host writes
    if (wr_cfg) begin
      st_d.cfg = cfg_masked(reg_wdata);
    end
    if (wr_lvl) begin
      st_d.lvl = reg_wdata;
    end
    // protection actions, override a coincident write
    trip_a = latch_trip(ol_a, ot, st_q.cfg);
    trip_b = latch_trip(ol_b, ot, st_q.cfg);
    if (trip_a || trip_b) begin
      st_d.lvl = {LVL_OFF, LVL_OFF};
    end
    // output enabled only when neither its own channel overload nor overtemperature is present
    st_d.en_a = chan_ok(ol_a, ot, trip_a);
    st_d.en_b = chan_ok(ol_b, ot, trip_b);
    st_d.addr = reg_addr;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // read mux, data valid one cycle after address
  always_comb begin
    case (st_q.addr)
      ADDR_DIAG_FLAGS: reg_rdata = st_q.flags;
      ADDR_DIAG_SPARE: reg_rdata = RST_BYTE;
      ADDR_LEVEL_SEL:  reg_rdata = st_q.lvl;
      ADDR_PROT_CFG:   reg_rdata = st_q.cfg;
      default:         reg_rdata = mem_rdata;
    endcase
  end

  // ==========================================================
  // output pins
  assign output_level_select_a = st_q.lvl[3:0];
  assign output_level_select_b = st_q.lvl[7:4];
  assign supply_output_en_a    = st_q.en_a && level_on(st_q.lvl[3:0]);
  assign supply_output_en_b    = st_q.en_b && level_on(st_q.lvl[7:4]);
  assign boost_comp_ceramic    = st_q.cfg[CFG_COMP_BIT];
endmodule
`default_nettype wire

// ---- spd_checker_assertions.sv ----
// assertion checker for the protection register bank
`timescale 1ns/1ps
`default_nettype none
module spd_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       overload_a_raw,
  input wire logic       overload_b_raw,
  input wire logic       overtemp_raw,
  input wire logic       low_input_raw,
  input wire logic [3:0] output_level_select_a,
  input wire logic [3:0] output_level_select_b,
  input wire logic       boost_comp_ceramic
);
  logic [7:0] c_q;
  logic [7:0] a_q;
  wire  logic s = reg_addr == a_q;
  always_ff @(posedge clk) begin
    c_q <= !resetn ? 8'h00 : (reg_wr && reg_addr == 8'h05) ? reg_wdata : c_q;
    a_q <= reg_addr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_cfg; reg_wr && reg_addr == 8'h05 |=> boost_comp_ceramic == c_q[7]; endproperty
  a_cfg: assert property (p_cfg) else $error("comp bit");
  property p_ol; s && reg_addr == 8'h00 |-> reg_rdata[1:0] ==
    {$past(overload_b_raw, 3), $past(overload_a_raw, 3)}; endproperty
  a_ol: assert property (p_ol) else $error("overload flags");
  property p_hi; s && reg_addr == 8'h00 |-> reg_rdata[7:2] ==
    {$past(low_input_raw, 3), $past(overtemp_raw, 3), 4'h0}; endproperty
  a_hi: assert property (p_hi) else $error("upper flags");
  property p_sp; s && reg_addr == 8'h01 |-> reg_rdata == 8'h00; endproperty
  a_sp: assert property (p_sp) else $error("spare reg");
  property p_olt; c_q[3] && $past(overload_a_raw, 3) |->
    output_level_select_a == 4'h0; endproperty
  a_olt: assert property (p_olt) else $error("overload latch");
  property p_ott; c_q[6] && $past(overtemp_raw, 3) |->
    output_level_select_b == 4'h0; endproperty
  a_ott: assert property (p_ott) else $error("thermal latch");
  property p_keep; !c_q[3] && !c_q[6] && !reg_wr |=> $stable(output_level_select_a); endproperty
  a_keep: assert property (p_keep) else $error("level kept");
  property p_lvl; reg_wr && reg_addr == 8'h02 && !c_q[3] && !c_q[6] |=>
    {output_level_select_b, output_level_select_a} == $past(reg_wdata); endproperty
  a_lvl: assert property (p_lvl) else $error("level write");
  c_ol: cover property (c_q[3] && $past(overload_a_raw, 3));
  c_ot: cover property (c_q[6] && $past(overtemp_raw, 3));
  c_wr: cover property (reg_wr && reg_addr == 8'h00);
endmodule
bind spd_top spd_checker chk_u (.*);
`default_nettype wire

// ---- spd_host.sv ----
// host model issuing register writes and read selects
`timescale 1ns/1ps
`default_nettype none
module spd_host (
  input  wire logic       clk,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  initial {reg_wr, reg_addr, reg_wdata} = 17'h00000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 8'h05) ? (d & 8'hC8) : d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic sel(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- tb_spd_top.sv ----
// testbench for the protection register bank
`timescale 1ns/1ps
`default_nettype none
module tb_spd_top;
  logic       clk, resetn, wr, ola, olb, ot, li, ea, eb, comp;
  logic [7:0] addr, wd, rd;
  logic [3:0] la, lb;
  int         checks, fail_count;
  spd_host host_u (.clk(clk), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd));
  spd_top dut_u (.clk(clk), .resetn(resetn), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rd), .overload_a_raw(ola), .overload_b_raw(olb), .overtemp_raw(ot),
    .low_input_raw(li), .output_level_select_a(la), .output_level_select_b(lb),
    .supply_output_en_a(ea), .supply_output_en_b(eb), .boost_comp_ceramic(comp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.sel(a);
    #1 chk(rd, e);
  endtask
  task automatic t_cfg;
    rchk(8'h05, 8'h00);
    host_u.wr(8'h05, 8'hFF);
    rchk(8'h05, 8'hC8);
    chk({7'h00, comp}, 8'h01);
  endtask
  task automatic t_stat;
    host_u.wr(8'h00, 8'hFF);
    host_u.wr(8'h01, 8'hFF);
    {li, ot, olb, ola} <= 4'hF;
    repeat (3) @(posedge clk);
    rchk(8'h00, 8'hC3);
    rchk(8'h01, 8'h00);
    @(posedge clk);
    {li, ot, olb, ola} <= 4'h0;
    repeat (4) @(posedge clk);
    rchk(8'h00, 8'h00);
  endtask
  task automatic t_trip(input logic [7:0] c);
    host_u.wr(8'h05, c);
    host_u.wr(8'h02, 8'h21);
    {ot, ola} <= c[6] ? 2'b10 : 2'b01;
    repeat (5) @(posedge clk);
    #1 chk({lb, la}, (c[6] | c[3]) ? 8'h00 : 8'h21);
    chk({6'h00, eb, ea}, (c[6] | c[3]) ? 8'h00 : 8'h02);
    chk({7'h00, comp}, 8'h00);
    @(posedge clk);
    {ot, ola} <= 2'b00;
    rchk(8'h02, (c[6] | c[3]) ? 8'h00 : 8'h21);
    repeat (3) @(posedge clk);
    #1 chk({6'h00, eb, ea}, (c[6] | c[3]) ? 8'h00 : 8'h03);
    host_u.wr(8'h02, 8'h21);
    rchk(8'h02, 8'h21);
    chk({6'h00, eb, ea}, 8'h03);
  endtask
  task automatic end_sim;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {resetn, ola, olb, ot, li} = 5'h00;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_cfg;
    t_stat;
    t_trip(8'h08);
    t_trip(8'h40);
    t_trip(8'h00);
    end_sim;
  end
  initial begin
    #100000;
    fail_count++;
    end_sim;
  end
endmodule
`default_nettype wire
